// File: bench/watchdog_periodic_interrupt_bench.sv
// Purpose: Self-checking bench for the watchdog and periodic tick block.
// Assumes: BASE_DIV is shortened to 4, so one base tick is 4 clock cycles.
// Notes: The bench loops the watchdog reset request back onto rst_n_i by hand.
`timescale 1ns/10ps
module watchdog_periodic_interrupt_bench import wdp_pkg::*;;
  localparam int unsigned DIV = 4;
  logic ref_clk_i;
  logic rst_n_i;
  logic por_n_i;
  wdp_apb_req_s apb_req;
  wdp_apb_rsp_s apb_rsp;
  logic irq;
  logic wd_reset;
  int err_total;
  int samples_checked;
  int n;
  logic [31:0] rd;
  logic [31:0] c1;
  logic err;
  int cyc = 0;

  wdp_top #(.BASE_DIV(DIV)) wdp_top_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .por_n_i(por_n_i),
    .apb_i(apb_req),
    .apb_o(apb_rsp),
    .irq_o(irq),
    .wd_reset_o(wd_reset)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) cyc <= cyc + 1;

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wdata);
    @(posedge ref_clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge ref_clk_i);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    cmp("pready", 32'h1, {31'h0, apb_rsp.pready});
  endtask

  // Counts cycles until the chosen output reaches val, at most bound cycles.
  task automatic wait_for(input logic use_irq, input logic val, input int bound);
    n = 0;
    while ((use_irq ? irq : wd_reset) !== val && n < bound) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask

  // Clears the periodic flag, then stamps the cycle at which the interrupt rises again.
  task automatic tick_wait(input logic chk, output int t);
    apb(1'b1, OFF_TICK_STAT, 32'h0000_0001);
    wait_for(1'b1, 1'b0, 8);
    if (chk) cmp("irq cleared", 32'h1, {31'h0, n < 8});
    wait_for(1'b1, 1'b1, 200);
    t = cyc;
  endtask

  task automatic sys_reset(input logic por);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    por_n_i <= ~por;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
  endtask

  task automatic t_reset_values();
    apb(1'b0, OFF_WD_CTRL, 32'h0);
    cmp("ctrl reset", 32'h0000_002E, rd);
    apb(1'b0, OFF_TICK_CTRL, 32'h0);
    cmp("tick ctrl reset", 32'h0000_4000, rd);
    apb(1'b0, OFF_TICK_STAT, 32'h0);
    cmp("tick stat reset", 32'h0, rd);
    apb(1'b0, 16'h7034, 32'h0);
    cmp("unmapped err", 32'h1, {31'h0, err});
  endtask

  task automatic t_run_and_overflow();
    apb(1'b1, OFF_WD_CTRL, 32'h0000_0028);
    apb(1'b1, OFF_WD_KEY, 32'h0000_005A);
    apb(1'b0, OFF_WD_COUNT, 32'h0);
    c1 = rd;
    repeat (100) @(posedge ref_clk_i);
    apb(1'b0, OFF_WD_COUNT, 32'h0);
    cmp("count advance", 32'h1, {31'h0, (rd - c1) >= 24 && (rd - c1) <= 27});
    cmp("no reset on key", 32'h0, {31'h0, wd_reset});
    apb(1'b1, OFF_WD_KEY, 32'h0000_005A);
    wait_for(1'b0, 1'b1, 1100);
    cmp("overflow time", 32'h1, {31'h0, n >= 1016 && n <= 1032});
    repeat (5) @(posedge ref_clk_i);
    cmp("reset held", 32'h1, {31'h0, wd_reset});
    sys_reset(1'b0);
    apb(1'b0, OFF_WD_CTRL, 32'h0);
    cmp("cause flag set", 32'h0000_00AE, rd);
    apb(1'b1, OFF_WD_CTRL, 32'h0000_00AE);
    apb(1'b0, OFF_WD_CTRL, 32'h0);
    cmp("cause flag clear", 32'h0000_002E, rd);
  endtask

  task automatic t_bad_writes();
    apb(1'b1, OFF_WD_KEY, 32'h0000_0033);
    wait_for(1'b0, 1'b1, 5);
    cmp("bad key reset", 32'h1, {31'h0, n <= 3});
    sys_reset(1'b0);
    apb(1'b0, OFF_WD_CTRL, 32'h0);
    cmp("flag after bad key", 32'h1, {31'h0, rd[CTRL_FLAG_BIT]});
    sys_reset(1'b1);
    apb(1'b1, OFF_WD_CTRL, 32'h0000_0030);
    wait_for(1'b0, 1'b1, 5);
    cmp("bad check reset", 32'h1, {31'h0, n <= 3});
    sys_reset(1'b1);
    apb(1'b0, OFF_WD_CTRL, 32'h0);
    cmp("ctrl after por", 32'h0000_002E, rd);
  endtask

  task automatic t_tick();
    int p[2] = '{1, 8};
    int t0;
    int t1;
    apb(1'b1, OFF_TICK_CTRL, 32'h0000_0004);
    repeat (40) @(posedge ref_clk_i);
    apb(1'b0, OFF_TICK_STAT, 32'h0);
    cmp("tick flag polled", 32'h1, rd);
    cmp("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_TICK_CTRL, 32'h0000_8004);
    repeat (3) @(posedge ref_clk_i);
    cmp("irq enabled", 32'h1, {31'h0, irq});
    foreach (p[i]) begin
      apb(1'b1, OFF_TICK_CTRL, 32'h0000_8000 | p[i]);
      tick_wait(1'b0, t0);
      tick_wait(1'b1, t0);
      tick_wait(1'b1, t1);
      c1 = ((p[i] < TICK_DIV_MIN) ? TICK_DIV_MIN : p[i]) * DIV;
      cmp("tick interval", c1, t1 - t0);
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    stop_test();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    por_n_i = 1'b0;
    apb_req = '0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    t_reset_values();
    t_run_and_overflow();
    t_bad_writes();
    t_tick();
    stop_test();
  end
endmodule

// File: core/wdp_pkg.sv
// Purpose: Shared constants and carrier types of the watchdog and periodic tick block.
// Assumes: 125 MHz reference clock; APB with 32-bit data and 16-bit byte addresses.
// Notes: All offsets are byte addresses inside the peripheral control frame.
package wdp_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;

  // Watchdog overflow periods, longest and shortest.
  localparam int unsigned WD_PERIOD_MAX_MS = 1000;
  localparam int unsigned WD_PERIOD_MIN_US = 15630;
  localparam int unsigned WD_STEPS = 256;
  localparam int unsigned WD_SEL_MAX = 6;
  localparam int unsigned WD_CNT_W = 8;
  localparam int unsigned WD_DIV_W = 6;

  // Common base tick that feeds both the watchdog and the periodic divider.
  localparam int unsigned BASE_HZ = WD_STEPS * (2 ** WD_SEL_MAX) * 1000 / WD_PERIOD_MAX_MS;
  localparam int unsigned BASE_CYCLES = CLK_HZ / BASE_HZ;

  // Periodic tick rates in events per second.
  localparam int unsigned TICK_RATE_MIN = 1;
  localparam int unsigned TICK_RATE_MAX = 4096;
  localparam int unsigned TICK_PER_W = 15;
  localparam logic [TICK_PER_W-1:0] TICK_DIV_MIN = TICK_PER_W'(BASE_HZ / TICK_RATE_MAX);
  localparam logic [TICK_PER_W-1:0] TICK_DIV_MAX = TICK_PER_W'(BASE_HZ / TICK_RATE_MIN);

  // Register map.
  localparam int unsigned ADDR_W = 16;
  localparam logic [ADDR_W-1:0] OFF_WD_COUNT = 16'h7020;
  localparam logic [ADDR_W-1:0] OFF_WD_KEY = 16'h7024;
  localparam logic [ADDR_W-1:0] OFF_WD_CTRL = 16'h7028;
  localparam logic [ADDR_W-1:0] OFF_TICK_CTRL = 16'h702C;
  localparam logic [ADDR_W-1:0] OFF_TICK_STAT = 16'h7030;

  // Watchdog control register fields.
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_SEL_W = 3;
  localparam int unsigned CTRL_CHK_LSB = 3;
  localparam int unsigned CTRL_CHK_W = 3;
  localparam int unsigned CTRL_FLAG_BIT = 7;
  localparam logic [CTRL_CHK_W-1:0] CTRL_CHK_OK = 3'h5;
  localparam logic [CTRL_SEL_W-1:0] CTRL_SEL_RST = 3'h6;

  // Service key.
  localparam int unsigned KEY_W = 8;
  localparam logic [KEY_W-1:0] KEY_GOOD = 8'h5A;

  // Periodic tick control and status fields.
  localparam int unsigned TICK_PER_LSB = 0;
  localparam int unsigned TICK_EN_BIT = 15;
  localparam logic [TICK_PER_W-1:0] TICK_PER_RST = 15'h4000;
  localparam int unsigned TICK_FLAG_BIT = 0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } wdp_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wdp_apb_rsp_s;

endpackage

// File: core/wdp_prescaler.sv
// Purpose: Divides the reference clock into a one-cycle base tick.
// Assumes: DIV is at least 2.
// Notes: The tick output is registered.
`timescale 1ns/10ps
module wdp_prescaler #(
  parameter int unsigned DIV = 7629,
  parameter int unsigned W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_tick;

  always_comb begin
    if (count == W'(DIV - 1)) begin
      next_count = '0;
      next_tick = 1'b1;
    end else begin
      next_count = count + W'(1);
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule

// File: core/wdp_top.sv
// Purpose: Watchdog timer and periodic tick interrupt behind an APB slave.
// Assumes: rst_n_i is the system reset that wd_reset_o requests; por_n_i is power-on only.
// Notes: wd_reset_o stays high until the system reset comes back on rst_n_i.
`timescale 1ns/10ps
module wdp_top import wdp_pkg::*; #(
  parameter int unsigned BASE_DIV = BASE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire wdp_apb_req_s apb_i,
  output wdp_apb_rsp_s apb_o,
  output logic irq_o,
  output logic wd_reset_o
);

  logic base_tick;
  logic [CTRL_SEL_W-1:0] wd_sel;
  logic [WD_DIV_W-1:0] wd_div;
  logic [WD_CNT_W-1:0] wd_count;
  logic cause_flag;
  logic [TICK_PER_W-1:0] tick_per;
  logic tick_en;
  logic [TICK_PER_W-1:0] tick_cnt;
  logic tick_flag;

  logic [CTRL_SEL_W-1:0] next_wd_sel;
  logic [WD_DIV_W-1:0] next_wd_div;
  logic [WD_CNT_W-1:0] next_wd_count;
  logic next_wd_reset;
  logic next_cause_flag;
  logic [TICK_PER_W-1:0] next_tick_per;
  logic next_tick_en;
  logic [TICK_PER_W-1:0] next_tick_cnt;
  logic next_tick_flag;
  logic next_irq;
  wdp_apb_rsp_s next_rsp;

  logic setup;
  logic wr;
  logic wr_key;
  logic wr_ctrl;
  logic wr_tctrl;
  logic wr_tstat;
  logic key_good;
  logic key_bad;
  logic chk_bad;
  logic [CTRL_SEL_W-1:0] sel_eff;
  logic [WD_DIV_W-1:0] wd_mask;
  logic wd_step;
  logic overflow;
  logic fire;
  logic [TICK_PER_W-1:0] tick_lim;
  logic tick_event;
  logic [31:0] tick_gap;
  logic [31:0] next_tick_gap;

  // Shared base tick for the watchdog and the periodic divider.
  wdp_prescaler #(
    .DIV(BASE_DIV),
    .W(16)
  ) u_base (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(base_tick)
  );

  // Bus decode; writes act at the edge that closes the access phase.
  always_comb begin
    setup = apb_i.psel && !apb_i.penable;
    wr = apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite;
    wr_key = wr && (apb_i.paddr == OFF_WD_KEY);
    wr_ctrl = wr && (apb_i.paddr == OFF_WD_CTRL);
    wr_tctrl = wr && (apb_i.paddr == OFF_TICK_CTRL);
    wr_tstat = wr && (apb_i.paddr == OFF_TICK_STAT);
    key_good = wr_key && (apb_i.pwdata[KEY_W-1:0] == KEY_GOOD);
    key_bad = wr_key && (apb_i.pwdata[KEY_W-1:0] != KEY_GOOD);
    chk_bad = wr_ctrl &&
      (apb_i.pwdata[CTRL_CHK_LSB +: CTRL_CHK_W] != CTRL_CHK_OK);
  end

  // Watchdog: the select code picks how many base ticks make one counter step.
  always_comb begin
    sel_eff = (wd_sel > CTRL_SEL_W'(WD_SEL_MAX)) ? CTRL_SEL_W'(WD_SEL_MAX) : wd_sel;
    wd_mask = WD_DIV_W'((7'h01 << sel_eff) - 7'h01);
    wd_step = base_tick && ((wd_div & wd_mask) == wd_mask);
    overflow = wd_step && (wd_count == {WD_CNT_W{1'b1}});
    fire = overflow || key_bad || chk_bad;

    next_wd_div = wd_div;
    next_wd_count = wd_count;
    if (key_good) begin
      next_wd_div = '0;
      next_wd_count = '0;
    end else if (base_tick) begin
      next_wd_div = wd_div + WD_DIV_W'(1);
      if (wd_step) begin
        next_wd_count = wd_count + WD_CNT_W'(1);
      end
    end

    next_wd_reset = wd_reset_o || fire;
    next_wd_sel = wd_sel;
    if (wr_ctrl && !chk_bad) begin
      next_wd_sel = apb_i.pwdata[CTRL_SEL_LSB +: CTRL_SEL_W];
    end

    // A new cause wins over a clear in the same cycle.
    next_cause_flag = fire || (cause_flag &&
      !(wr_ctrl && !chk_bad && apb_i.pwdata[CTRL_FLAG_BIT]));
  end

  // Periodic tick: the period is a count of base ticks, held to the legal range.
  always_comb begin
    if (tick_per < TICK_DIV_MIN) begin
      tick_lim = TICK_DIV_MIN;
    end else if (tick_per > TICK_DIV_MAX) begin
      tick_lim = TICK_DIV_MAX;
    end else begin
      tick_lim = tick_per;
    end
    tick_event = base_tick && (tick_cnt >= tick_lim - TICK_PER_W'(1));

    next_tick_cnt = tick_cnt;
    if (tick_event) begin
      next_tick_cnt = '0;
    end else if (base_tick) begin
      next_tick_cnt = tick_cnt + TICK_PER_W'(1);
    end

    next_tick_per = tick_per;
    next_tick_en = tick_en;
    if (wr_tctrl) begin
      next_tick_per = apb_i.pwdata[TICK_PER_LSB +: TICK_PER_W];
      next_tick_en = apb_i.pwdata[TICK_EN_BIT];
    end

    // Sticky status, write one to clear; a fresh event wins over the clear.
    next_tick_flag = tick_event ||
      (tick_flag && !(wr_tstat && apb_i.pwdata[TICK_FLAG_BIT]));
    next_irq = next_tick_flag && next_tick_en;
  end

  // Cycles since the last periodic event, saturating at the shortest legal spacing.
  localparam int unsigned GAP_MIN = 32'(TICK_DIV_MIN) * BASE_DIV;

  always_comb begin
    next_tick_gap = tick_gap;
    if (tick_event) begin
      next_tick_gap = 32'h0000_0001;
    end else if (tick_gap < 32'(GAP_MIN)) begin
      next_tick_gap = tick_gap + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tick_gap <= 32'(GAP_MIN);
    end else begin
      tick_gap <= next_tick_gap;
    end
  end

  // Read data and the ready answer are prepared during the setup cycle.
  always_comb begin
    next_rsp = '0;
    if (setup) begin
      next_rsp.pready = 1'b1;
      unique case (apb_i.paddr)
        OFF_WD_COUNT: next_rsp.prdata = 32'(wd_count);
        OFF_WD_KEY: next_rsp.prdata = 32'h0000_0000;
        OFF_WD_CTRL: begin
          next_rsp.prdata[CTRL_SEL_LSB +: CTRL_SEL_W] = wd_sel;
          next_rsp.prdata[CTRL_CHK_LSB +: CTRL_CHK_W] = CTRL_CHK_OK;
          next_rsp.prdata[CTRL_FLAG_BIT] = cause_flag;
        end
        OFF_TICK_CTRL: begin
          next_rsp.prdata[TICK_PER_LSB +: TICK_PER_W] = tick_per;
          next_rsp.prdata[TICK_EN_BIT] = tick_en;
        end
        OFF_TICK_STAT: next_rsp.prdata[TICK_FLAG_BIT] = tick_flag;
        default: next_rsp.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wd_sel <= CTRL_SEL_RST;
      wd_div <= '0;
      wd_count <= '0;
      wd_reset_o <= 1'b0;
      tick_per <= TICK_PER_RST;
      tick_en <= 1'b0;
      tick_cnt <= '0;
      tick_flag <= 1'b0;
      irq_o <= 1'b0;
      apb_o <= '0;
    end else begin
      wd_sel <= next_wd_sel;
      wd_div <= next_wd_div;
      wd_count <= next_wd_count;
      wd_reset_o <= next_wd_reset;
      tick_per <= next_tick_per;
      tick_en <= next_tick_en;
      tick_cnt <= next_tick_cnt;
      tick_flag <= next_tick_flag;
      irq_o <= next_irq;
      apb_o <= next_rsp;
    end
  end

  // The cause flag survives the system reset it requested.
  always_ff @(posedge ref_clk_i) begin
    if (!por_n_i) begin
      cause_flag <= 1'b0;
    end else begin
      cause_flag <= next_cause_flag;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_bad_key;
    key_bad && !wd_reset_o;
  endsequence

  sequence s_bad_check;
    chk_bad && !wd_reset_o;
  endsequence

  sequence s_good_key;
    key_good && !fire;
  endsequence

  sequence s_tick_then_quiet;
    tick_event ##1 !tick_event [*3];
  endsequence

  a_good_key_clears: assert property (s_good_key |=> (wd_count == '0) && !wd_reset_o)
    else $error("Correct key did not clear the watchdog counter.");

  a_bad_key_resets: assert property (s_bad_key |=> wd_reset_o && cause_flag)
    else $error("Wrong key did not request a system reset.");

  a_check_bits_reset: assert property (s_bad_check |=> wd_reset_o ##1 wd_reset_o)
    else $error("Bad check pattern did not request a system reset.");

  a_overflow_resets: assert property (overflow |=> wd_reset_o)
    else $error("Watchdog overflow did not request a system reset.");

  a_cause_recorded: assert property ($rose(wd_reset_o) |-> cause_flag)
    else $error("Watchdog reset left the cause flag clear.");

  a_counter_steps: assert property (
    wd_step && !key_good |=> wd_count == $past(wd_count) + 8'h01)
    else $error("Watchdog counter did not advance on its step.");

  a_step_on_base: assert property (
    wd_step |-> base_tick && (wd_sel == 3'h0 || wd_div[0]))
    else $error("Watchdog stepped without a base tick.");

  a_tick_spacing: assert property (tick_event |-> s_tick_then_quiet)
    else $error("Periodic events closer than the fastest rate.");

  a_irq_follows: assert property (
    tick_event && tick_en && !wr_tctrl |=> irq_o && tick_flag)
    else $error("Enabled periodic event did not raise the interrupt.");

  a_flag_held: assert property (tick_flag && !wr_tstat |=> tick_flag)
    else $error("Periodic flag dropped without a clear.");

  a_irq_needs_en: assert property (!tick_en && !wr_tctrl |=> !irq_o)
    else $error("Interrupt raised while the periodic enable was clear.");

  a_apb_ready: assert property (setup |=> apb_o.pready ##1 !apb_o.pready)
    else $error("APB access phase did not complete in one cycle.");

  a_tick_gap: assert property (tick_event |-> tick_gap >= 32'(GAP_MIN))
    else $error("Periodic events closer than the shortest period.");

  a_reset_sticks: assert property (wd_reset_o |=> wd_reset_o)
    else $error("System reset request dropped before reset came.");

  a_flag_clears: assert property (
    wr_tstat && apb_i.pwdata[TICK_FLAG_BIT] && !tick_event |=> !tick_flag && !irq_o)
    else $error("Write of one did not clear the periodic flag.");

  a_irq_matches: assert property (irq_o == (tick_flag && tick_en))
    else $error("Interrupt level differs from flag and enable.");

endmodule
